// [logic/lsrc_consts.vh]
// Constants for the loop and synthesizer rate configuration block
`ifndef LSRC_CONSTS_VH
`define LSRC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define LSRC_ADDR_REF3_LIMITS 7'h4e
`define LSRC_ADDR_LOOP_CTRL 7'h4f
`define LSRC_ADDR_BASE_LO 7'h50
`define LSRC_ADDR_BASE_HI 7'h51
`define LSRC_ADDR_MULT_LO 7'h52
`define LSRC_ADDR_MULT_HI 7'h53

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LSRC_RST_REF3_LIMITS 8'h55
`define LSRC_RST_LOOP_CTRL 8'hf1
`define LSRC_RST_BASE 16'h9c40
`define LSRC_RST_MULT 16'h0798
`define LSRC_RST_RATIO 16'h0001

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define LSRC_LOOP_EN_BIT 0
`define LSRC_ACQ_EN_BIT 4
`define LSRC_LOOP_WR_MASK 8'h11
`define LSRC_REF3_WR_MASK 8'h7f
`define LSRC_SYNTH_SCALE_SHIFT 4

`endif

// [logic/lsrc_rate_calc.v]
// Synthesizer frequency computation from base, multiplier and ratio
`timescale 1ns/100ps
module lsrc_rate_calc (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [15:0] base_rate_i,
  input wire [15:0] rate_multiplier_i,
  input wire [15:0] ratio_numerator_i,
  input wire [15:0] ratio_denominator_i,
  output reg [35:0] synth_freq_hz_o,
  output reg ratio_error_o
);
`include "lsrc_consts.vh"

  reg [31:0] base_times_mult;
  reg [51:0] scaled;
  reg [67:0] product;
  reg [67:0] quotient;

  // Divide left to the synthesis tool; config values are quasi-static
  always @* begin
    // Widen first; a bare product inside a concatenation keeps only 16 bits
    base_times_mult = {16'h0000, base_rate_i} * {16'h0000, rate_multiplier_i};
    scaled = {20'h00000, base_times_mult} << `LSRC_SYNTH_SCALE_SHIFT;
    product = scaled * {52'h0, ratio_numerator_i};
    if (ratio_denominator_i == 16'h0000) begin
      quotient = 68'h0;
    end else begin
      quotient = product / {52'h0, ratio_denominator_i};
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      synth_freq_hz_o <= 36'h0;
      ratio_error_o <= 1'b0;
    end else begin
      synth_freq_hz_o <= quotient[35:0];
      ratio_error_o <= (ratio_denominator_i == 16'h0000) | (|quotient[67:36]);
    end
  end
endmodule // lsrc_rate_calc

// [logic/lsrc_top.v]
// Loop control and first synthesizer rate configuration registers
//
// Overview of operation
// - Loop control bit 0 enables the loop
// - Loop control bit 4 enables phase acquisition
// - Base rate is unsigned hertz
// - Frequency is base times multiplier times 16 scaled
`timescale 1ns/100ps
module lsrc_top (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [15:0] ratio_numerator_i,
  input wire [15:0] ratio_denominator_i,
  output reg [7:0] reg_rdata_o,
  output wire reg_hit_o,
  output wire loop_enable_o,
  output wire acq_enable_o,
  output wire [15:0] base_rate_o,
  output wire [15:0] rate_multiplier_o,
  output wire [35:0] synth_freq_hz_o,
  output wire ratio_error_o
);
`include "lsrc_consts.vh"

  // ----------------------------------------------------------------------
  // Register select codes, one bit per mapped byte
  // ----------------------------------------------------------------------
  localparam SEL_NONE = 6'b000000;
  localparam SEL_REF3 = 6'b000001;
  localparam SEL_LOOP = 6'b000010;
  localparam SEL_BASE_LO = 6'b000100;
  localparam SEL_BASE_HI = 6'b001000;
  localparam SEL_MULT_LO = 6'b010000;
  localparam SEL_MULT_HI = 6'b100000;

  // ----------------------------------------------------------------------
  // Storage and next values
  // ----------------------------------------------------------------------
  reg [7:0] ref3_monitor_limits;
  reg [7:0] loop_control;
  reg [15:0] synth_a_base_rate;
  reg [15:0] synth_a_rate_multiplier;
  reg [7:0] next_ref3_monitor_limits;
  reg [7:0] next_loop_control;
  reg [15:0] next_synth_a_base_rate;
  reg [15:0] next_synth_a_rate_multiplier;
  reg [7:0] next_rdata;
  wire [5:0] sel;
  wire [5:0] wr_sel;
  wire [5:0] rd_sel;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Shared by write and read paths so both always agree on the map
  function [5:0] reg_select;
    input [6:0] addr;
    begin
      if (addr == `LSRC_ADDR_REF3_LIMITS) begin
        reg_select = SEL_REF3;
      end else if (addr == `LSRC_ADDR_LOOP_CTRL) begin
        reg_select = SEL_LOOP;
      end else if (addr == `LSRC_ADDR_BASE_LO) begin
        reg_select = SEL_BASE_LO;
      end else if (addr == `LSRC_ADDR_BASE_HI) begin
        reg_select = SEL_BASE_HI;
      end else if (addr == `LSRC_ADDR_MULT_LO) begin
        reg_select = SEL_MULT_LO;
      end else if (addr == `LSRC_ADDR_MULT_HI) begin
        reg_select = SEL_MULT_HI;
      end else begin
        reg_select = SEL_NONE;
      end
    end
  endfunction

  // Keep-default bits hold their reset value whatever is written
  function [7:0] masked_write;
    input [7:0] rst_val;
    input [7:0] wmask;
    input [7:0] wdata;
    begin
      masked_write = (wdata & wmask) | (rst_val & ~wmask);
    end
  endfunction

  // Each byte lands alone; no shadow copy of the other half
  function [15:0] set_low_byte;
    input [15:0] cur;
    input [7:0] data;
    begin
      set_low_byte = {cur[15:8], data};
    end
  endfunction

  function [15:0] set_high_byte;
    input [15:0] cur;
    input [7:0] data;
    begin
      set_high_byte = {data, cur[7:0]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign sel = reg_select(reg_addr_i);
  assign wr_sel = reg_wr_i ? sel : SEL_NONE;
  assign rd_sel = reg_rd_i ? sel : SEL_NONE;
  assign reg_hit_o = |(wr_sel | rd_sel);

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @* begin
    next_ref3_monitor_limits = ref3_monitor_limits;
    next_loop_control = loop_control;
    next_synth_a_base_rate = synth_a_base_rate;
    next_synth_a_rate_multiplier = synth_a_rate_multiplier;
    if (wr_sel[0]) begin
      next_ref3_monitor_limits = masked_write(`LSRC_RST_REF3_LIMITS,
                                              `LSRC_REF3_WR_MASK,
                                              reg_wdata_i);
    end
    if (wr_sel[1]) begin
      next_loop_control = masked_write(`LSRC_RST_LOOP_CTRL,
                                       `LSRC_LOOP_WR_MASK,
                                       reg_wdata_i);
    end
    if (wr_sel[2]) begin
      next_synth_a_base_rate = set_low_byte(synth_a_base_rate, reg_wdata_i);
    end
    if (wr_sel[3]) begin
      next_synth_a_base_rate = set_high_byte(synth_a_base_rate, reg_wdata_i);
    end
    if (wr_sel[4]) begin
      next_synth_a_rate_multiplier = set_low_byte(synth_a_rate_multiplier, reg_wdata_i);
    end
    if (wr_sel[5]) begin
      next_synth_a_rate_multiplier = set_high_byte(synth_a_rate_multiplier,
                                                   reg_wdata_i);
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ref3_monitor_limits <= `LSRC_RST_REF3_LIMITS;
      loop_control <= `LSRC_RST_LOOP_CTRL;
      synth_a_base_rate <= `LSRC_RST_BASE;
      synth_a_rate_multiplier <= `LSRC_RST_MULT;
    end else begin
      ref3_monitor_limits <= next_ref3_monitor_limits;
      loop_control <= next_loop_control;
      synth_a_base_rate <= next_synth_a_base_rate;
      synth_a_rate_multiplier <= next_synth_a_rate_multiplier;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, registered; unmapped reads return zero
  // ----------------------------------------------------------------------
  // A read in the same cycle as a write returns the old contents
  always @* begin
    if (sel[0]) begin
      next_rdata = ref3_monitor_limits;
    end else if (sel[1]) begin
      next_rdata = loop_control;
    end else if (sel[2]) begin
      next_rdata = synth_a_base_rate[7:0];
    end else if (sel[3]) begin
      next_rdata = synth_a_base_rate[15:8];
    end else if (sel[4]) begin
      next_rdata = synth_a_rate_multiplier[7:0];
    end else if (sel[5]) begin
      next_rdata = synth_a_rate_multiplier[15:8];
    end else begin
      next_rdata = 8'h00;
    end
  end

  // Held between reads so software can sample it late
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Power enables and synthesizer rate
  // ----------------------------------------------------------------------
  assign loop_enable_o = loop_control[`LSRC_LOOP_EN_BIT];
  assign acq_enable_o = loop_control[`LSRC_ACQ_EN_BIT];
  assign base_rate_o = synth_a_base_rate;
  assign rate_multiplier_o = synth_a_rate_multiplier;

  // Ratio lives in neighbouring registers; defaults of one give plain rates
  lsrc_rate_calc u_rate_calc (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .base_rate_i(synth_a_base_rate),
    .rate_multiplier_i(synth_a_rate_multiplier),
    .ratio_numerator_i(ratio_numerator_i),
    .ratio_denominator_i(ratio_denominator_i),
    .synth_freq_hz_o(synth_freq_hz_o),
    .ratio_error_o(ratio_error_o)
  );
endmodule // lsrc_top

// [test/lsrc_top_sva.sv]
// Assertion checker for the rate configuration block
`timescale 1ns/100ps
module lsrc_top_chk (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [6:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [15:0] ratio_numerator_i,
  input wire [15:0] ratio_denominator_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_hit_o,
  input wire loop_enable_o,
  input wire acq_enable_o,
  input wire [15:0] base_rate_o,
  input wire [15:0] rate_multiplier_o,
  input wire [35:0] synth_freq_hz_o,
  input wire ratio_error_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire wl = reg_wr_i && reg_addr_i == 7'h4f;
  // Widened so the product never wraps before the range test
  wire [63:0] calc = {48'h0, base_rate_o} * rate_multiplier_o * 64'h10 * ratio_numerator_i
    / ratio_denominator_i;
  wire wb_lo = reg_wr_i && reg_addr_i == 7'h50;
  wire wb_hi = reg_wr_i && reg_addr_i == 7'h51;
  wire wm_lo = reg_wr_i && reg_addr_i == 7'h52;
  wire rl = reg_rd_i && reg_addr_i == 7'h4f;
  loop_en_a: assert property (wl |=> loop_enable_o == $past(reg_wdata_i[0]))
    else $error("loop enable wrong");
  acq_en_a: assert property (wl |-> ##1 acq_enable_o == $past(reg_wdata_i[4]))
    else $error("acquisition enable wrong");
  base_lo_a: assert property (wb_lo |=> base_rate_o[7:0] == $past(reg_wdata_i))
    else $error("base low byte wrong");
  base_hi_a: assert property (wb_hi |-> ##1 base_rate_o[15:8] == $past(reg_wdata_i))
    else $error("base high byte wrong");
  mult_lo_a: assert property (wm_lo |=> rate_multiplier_o[7:0] == $past(reg_wdata_i))
    else $error("multiplier low byte wrong");
  freq_calc_a: assert property (ratio_denominator_i != 16'h0 && calc < 64'h10_0000_0000
    |=> synth_freq_hz_o == $past(calc[35:0])) else $error("frequency wrong");
  ratio_err_a: assert property (ratio_denominator_i == 16'h0 |=> ratio_error_o)
    else $error("zero divisor not flagged");
  rsvd_bits_a: assert property (rl |=> reg_rdata_o[7:5] == 3'h7 && reg_rdata_o[3:1] == 3'h0)
    else $error("reserved bits changed");
  cover property (wl);
  cover property (ratio_denominator_i == 16'h0);
  cover property (reg_rd_i && !reg_hit_o);
endmodule // lsrc_top_chk

// [test/test_lsrc_top.sv]
// Self-checking bench for the rate configuration block
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_lsrc_top;
  reg clk = 0, rst_n = 0, wr = 0, rd = 0;
  reg [6:0] ad = 0;
  reg [7:0] wd = 0;
  reg [15:0] num = 1, den = 1, b, m;
  reg [31:0] rng = 32'h013e0668;
  reg [31:0] tgt;
  reg [15:0] codes [0:6] = '{16'h1388, 16'h186a, 16'h1f40, 16'h2710, 16'h30d4, 16'h61a8, 16'h9c40};
  integer fail_count = 0, check_count = 0, i;
  wire [7:0] rdat;
  wire hit, le, ae, err;
  wire [15:0] bo, mo;
  wire [35:0] fo;
  lsrc_top u_lsrc_top (.core_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(ad), .reg_wdata_i(wd), .ratio_numerator_i(num), .ratio_denominator_i(den),
    .reg_rdata_o(rdat), .reg_hit_o(hit), .loop_enable_o(le), .acq_enable_o(ae),
    .base_rate_o(bo), .rate_multiplier_o(mo), .synth_freq_hz_o(fo), .ratio_error_o(err));
  function [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  function [35:0] fx(input [63:0] bb, mm, nn, dd);
    fx = 36'(bb * mm * 64'h10 * nn / dd);
  endfunction
  // Rounds up so the base product never falls under the target
  function [15:0] mult_for(input [31:0] t, input [15:0] bb);
    mult_for = 16'((t + bb * 32'd16 - 32'd1) / (bb * 32'd16));
  endfunction
  task wreg(input [6:0] a, input [7:0] d);
    @(posedge clk); wr <= 1; ad <= a; wd <= d;
    @(posedge clk); wr <= 0;
    #1;
  endtask
  task rreg(input [6:0] a, input [7:0] e);
    @(posedge clk); rd <= 1; ad <= a;
    #1 `CHK(hit, (a >= 7'h4e && a <= 7'h53))
    @(posedge clk); rd <= 0;
    #1 `CHK(rdat, e)
  endtask
  task set_rate(input [15:0] bb, input [15:0] mm);
    wreg(7'h50, bb[7:0]);
    wreg(7'h51, bb[15:8]);
    wreg(7'h52, mm[7:0]);
    wreg(7'h53, mm[15:8]);
    @(posedge clk);
    #1 `CHK(fo, fx(bb, mm, num, den))
    `CHK({bo, mo}, {bb, mm})
    `CHK(err, 1'b0)
  endtask
  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  // Bound well above the expected run of a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rreg(7'h4e, 8'h55);
    rreg(7'h4f, 8'hf1);
    rreg(7'h50, 8'h40);
    rreg(7'h51, 8'h9c);
    rreg(7'h53, 8'h07);
    `CHK(fo, 36'd1244160000)
    wreg(7'h4f, 8'h01);
    `CHK({le, ae}, 2'b10)
    wreg(7'h4f, 8'hfe);
    `CHK({le, ae}, 2'b01)
    rreg(7'h4f, 8'hf0);
    wreg(7'h4e, 8'hff);
    rreg(7'h4e, 8'h7f);
    rreg(7'h54, 8'h00);
    for (i = 0; i < 20; i++) begin
      rng = xs(rng);
      b = codes[rng % 7];
      tgt = 32'd1000000000 + rng % 32'd299000000;
      m = mult_for(tgt, b);
      rng = xs(rng);
      @(posedge clk);
      den <= 16'd200 + rng[7:0];
      num <= 16'd200 + rng[7:0] + rng[11:8];
      set_rate(b, m);
    end
    @(posedge clk);
    num <= 16'h0001;
    den <= 16'h0001;
    set_rate(16'h1f40, 16'h2000);
    set_rate(16'h61a8, 16'h0c35);
    @(posedge clk);
    num <= 16'd255;
    den <= 16'd237;
    set_rate(16'h9c40, 16'h0798);
    @(posedge clk);
    rst_n <= 0;
    num <= 16'h0001;
    den <= 16'h0001;
    @(posedge clk);
    rst_n <= 1;
    #1 `CHK({le, ae}, 2'b11)
    `CHK({bo, mo, fo}, {16'h9c40, 16'h0798, 36'h0})
    @(posedge clk);
    #1 `CHK(fo, fx(16'h9c40, 16'h0798, 1, 1))
    rreg(7'h4f, 8'hf1);
    @(posedge clk);
    den <= 16'h0;
    repeat (2) @(posedge clk);
    #1 `CHK(err, 1'b1)
    end_of_test;
  end
endmodule // test_lsrc_top
bind lsrc_top lsrc_top_chk u_lsrc_top_chk (.*);
